/* sprc_top.sv */
// supply restart request, state flags, scratch byte and protection shutdowns
`timescale 1ns/10ps
module sprc_top #(
  parameter int NUM_OUT = sprc_pkg::NUM_OUT_DEFAULT,
  parameter int CYCLES_PER_MS = sprc_pkg::CYCLES_PER_MS
) (
  // clock and power-on reset from the undervoltage detector
  input wire logic sys_clk,
  input wire logic arst_n,
  // soft reset request, one cycle
  input wire logic softReset,
  // register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [sprc_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic [sprc_pkg::REG_DATA_W-1:0] regWrData,
  output logic [sprc_pkg::REG_DATA_W-1:0] regRdData,
  // comparator and pin flags, asynchronous
  input wire logic shortDetectRaw,
  input wire logic overTempRaw,
  input wire logic crystalOscRaw,
  input wire logic supplyEnablePinRaw,
  input wire logic [NUM_OUT-1:0] curLimitRaw,
  input wire logic [NUM_OUT-1:0] belowShortLevelRaw,
  // regulator sequencer
  output logic stopSeqReq,
  input wire logic stopSeqDone,
  output logic startSeqReq,
  output logic [NUM_OUT-1:0] outputStop
);
  import sprc_pkg::*;

  localparam int MS_CNT_W = $clog2(CYCLES_PER_MS);
  localparam int SYNC_W = 4 + 2 * NUM_OUT;
  localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(CYCLES_PER_MS - 1);

  if (CYCLES_PER_MS < 2) begin : g_bad_ms
    $error("CYCLES_PER_MS must be at least 2");
  end
  if (NUM_OUT < 1) begin : g_bad_out
    $error("NUM_OUT must be at least 1");
  end

  // synchronised flags
  logic [SYNC_W-1:0] flagsRaw;
  logic [SYNC_W-1:0] flagsSync;
  logic shortSync;
  logic overTempSync;
  logic oscSync;
  logic enablePinSync;
  logic [NUM_OUT-1:0] curLimitSync;
  logic [NUM_OUT-1:0] belowShortSync;

  // timebase
  logic [MS_CNT_W-1:0] msCnt_q;
  logic msTick_q;

  // restart control
  sprc_restart_state_t restartState_q;
  logic restartHist_q;
  logic [1:0] holdSel_q;
  logic [4:0] holdCnt_q;
  logic [4:0] holdTarget;
  logic ctrlWr;
  logic restartLaunch;
  logic holdDone;
  logic restartReqBit;
  logic stopSeqReq_q;
  logic startSeqReq_q;

  // scratch and read data
  logic [7:0] scratch_q;
  logic [7:0] regRdData_q;
  logic [7:0] stateFlags;

  // protection
  logic [6:0] shortCnt_q;
  logic shortLatch_q;
  logic [NUM_OUT-1:0] ocpLatch_q;
  logic [NUM_OUT-1:0] outputStop_q;

  assign flagsRaw = {belowShortLevelRaw, curLimitRaw, shortDetectRaw, overTempRaw,
                     crystalOscRaw, supplyEnablePinRaw};

  sprc_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .asyncIn(flagsRaw),
    .syncOut(flagsSync)
  );

  assign enablePinSync = flagsSync[0];
  assign oscSync = flagsSync[1];
  assign overTempSync = flagsSync[2];
  assign shortSync = flagsSync[3];
  assign curLimitSync = flagsSync[4 +: NUM_OUT];
  assign belowShortSync = flagsSync[4 + NUM_OUT +: NUM_OUT];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      msCnt_q <= '0;
      msTick_q <= 1'b0;
    end else begin
      msTick_q <= (msCnt_q == MS_LAST);
      if (msCnt_q == MS_LAST) begin
        msCnt_q <= '0;
      end else begin
        msCnt_q <= msCnt_q + 1'b1;
      end
    end
  end

  always_comb begin
    case (holdSel_q)
      2'h0: holdTarget = HOLD_MS_00;
      2'h1: holdTarget = HOLD_MS_01;
      2'h2: holdTarget = HOLD_MS_10;
      default: holdTarget = HOLD_MS_11;
    endcase
  end

  // a new request while one is pending is dropped; soft reset takes priority over the write
  assign ctrlWr = regWrEn && (regAddr == ADDR_RESTART_CTRL) && !softReset;
  assign restartLaunch = ctrlWr && regWrData[RESTART_REQ_BIT] && (restartState_q == RS_IDLE);
  // the extra tick makes the hold at least the selected time on a free-running tick
  assign holdDone = (restartState_q == RS_HOLD) && msTick_q && (holdCnt_q == holdTarget);
  // request bit reads one only while pending
  assign restartReqBit = (restartState_q == RS_STOP) || (restartState_q == RS_HOLD);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      restartState_q <= RS_IDLE;
    end else begin
      case (restartState_q)
        RS_IDLE: begin
          if (restartLaunch) begin
            restartState_q <= RS_STOP;
          end
        end
        RS_STOP: begin
          if (stopSeqDone) begin
            restartState_q <= RS_HOLD;
          end
        end
        RS_HOLD: begin
          if (holdDone) begin
            restartState_q <= RS_START;
          end
        end
        RS_START: restartState_q <= RS_IDLE;
        default: restartState_q <= RS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt_q <= '0;
    end else if (restartState_q != RS_HOLD) begin
      holdCnt_q <= '0;
    end else if (msTick_q && !holdDone) begin
      holdCnt_q <= holdCnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stopSeqReq_q <= 1'b0;
      startSeqReq_q <= 1'b0;
    end else begin
      stopSeqReq_q <= restartLaunch;
      startSeqReq_q <= holdDone;
    end
  end

  // history set with the request; the set beats a clear in the same write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      restartHist_q <= 1'b0;
    end else if (softReset) begin
      restartHist_q <= 1'b0;
    end else if (restartLaunch) begin
      restartHist_q <= 1'b1;
    end else if (ctrlWr && (regWrData == RESTART_CLEAR_VALUE)) begin
      restartHist_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      holdSel_q <= HOLD_SEL_RESET;
    end else if (softReset) begin
      holdSel_q <= HOLD_SEL_RESET;
    end else if (ctrlWr) begin
      holdSel_q <= regWrData[HOLD_SEL_HI:HOLD_SEL_LO];
    end
  end

  // scratch clears on soft reset; free read and write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scratch_q <= SCRATCH_RESET;
    end else if (softReset) begin
      scratch_q <= SCRATCH_RESET;
    end else if (regWrEn && (regAddr == ADDR_SCRATCH)) begin
      scratch_q <= regWrData;
    end
  end

  always_comb begin
    stateFlags = 8'h00;
    stateFlags[STATE_SHORT_BIT] = shortSync;
    stateFlags[STATE_OVERTEMP_BIT] = overTempSync;
    stateFlags[STATE_OSC_BIT] = oscSync;
    stateFlags[STATE_ENABLE_BIT] = enablePinSync;
  end

  // read data is held until the next read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData_q <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        ADDR_RESTART_CTRL: begin
          regRdData_q <= 8'h00;
          regRdData_q[RESTART_HIST_BIT] <= restartHist_q;
          regRdData_q[HOLD_SEL_HI:HOLD_SEL_LO] <= holdSel_q;
          regRdData_q[RESTART_REQ_BIT] <= restartReqBit;
        end
        ADDR_STATE_FLAGS: regRdData_q <= stateFlags;
        ADDR_SCRATCH: regRdData_q <= scratch_q;
        default: regRdData_q <= 8'h00;
      endcase
    end
  end

  // short must persist 100 ms ticks; any gap restarts the count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shortCnt_q <= '0;
    end else if (!shortSync) begin
      shortCnt_q <= '0;
    end else if (msTick_q && (shortCnt_q != SHORT_QUAL_MS)) begin
      shortCnt_q <= shortCnt_q + 1'b1;
    end
  end

  // latched until power-on reset only; arst_n is that reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shortLatch_q <= 1'b0;
    end else if (shortCnt_q == SHORT_QUAL_MS) begin
      shortLatch_q <= 1'b1;
    end
  end

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    // current-limited output stops below short level
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        ocpLatch_q[i] <= 1'b0;
      end else if (curLimitSync[i] && belowShortSync[i]) begin
        ocpLatch_q[i] <= 1'b1;
      end
    end

    // stop request; over-temperature releases on its own
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        outputStop_q[i] <= 1'b0;
      end else begin
        outputStop_q[i] <= shortLatch_q || overTempSync || ocpLatch_q[i];
      end
    end
  end

  assign regRdData = regRdData_q;
  assign stopSeqReq = stopSeqReq_q;
  assign startSeqReq = startSeqReq_q;
  assign outputStop = outputStop_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_hist_on_request: assert property (
    restartLaunch |=> restartHist_q && restartReqBit && stopSeqReq)
    else $error("history or request not set on restart");

  a_hist_set_wins: assert property (
    (ctrlWr && regWrData[RESTART_REQ_BIT] && restartState_q == RS_IDLE) |=> restartHist_q)
    else $error("clear beat the restart request");

  a_hist_one_ignored: assert property (
    (ctrlWr && !restartHist_q && !regWrData[RESTART_REQ_BIT]) |=> !restartHist_q)
    else $error("history set by a plain write");

  a_hist_zero_clear: assert property (
    (ctrlWr && regWrData == 8'h00 && restartState_q == RS_IDLE) |=> !restartHist_q)
    else $error("zero write did not clear history");

  a_hold_length: assert property (
    $rose(startSeqReq) |-> $past(holdCnt_q) == $past(holdTarget))
    else $error("hold ended at the wrong count");

  a_stop_before_start: assert property (
    (restartState_q == RS_STOP && stopSeqDone) |=> !startSeqReq ##1 (restartState_q == RS_HOLD))
    else $error("start launched without hold");

  a_request_clears: assert property (
    startSeqReq |-> !restartReqBit && restartState_q == RS_START)
    else $error("request bit still set after hold");

  a_state_read: assert property (
    (regRdEn && regAddr == ADDR_STATE_FLAGS) |=> regRdData[3:0] == $past(stateFlags[3:0])
      && regRdData[7:4] == 4'h0)
    else $error("state flags read wrong");

  a_scratch_clear: assert property (
    softReset |=> scratch_q == 8'h00)
    else $error("scratch survived soft reset");

  a_scratch_back: assert property (
    (regWrEn && regAddr == ADDR_SCRATCH && !softReset) ##1 (regRdEn && regAddr == ADDR_SCRATCH
      && !softReset && !regWrEn) |=> regRdData == $past(regWrData, 2))
    else $error("scratch read-back mismatch");

  a_short_latch: assert property (
    shortLatch_q |=> shortLatch_q && outputStop == {NUM_OUT{1'b1}})
    else $error("short shutdown released");

  a_short_qualify: assert property (
    (shortCnt_q == SHORT_QUAL_MS - 7'h01 && shortSync && msTick_q) |=> ##1 shortLatch_q)
    else $error("short not latched at count end");

  a_otp_stop: assert property (
    overTempSync |=> outputStop == {NUM_OUT{1'b1}})
    else $error("over-temperature did not stop outputs");

  a_ocp_stop: assert property (
    (curLimitSync[0] && belowShortSync[0]) |=> ##1 outputStop[0])
    else $error("current-limited output not stopped");

  c_restart_done: cover property (restartState_q == RS_HOLD ##1 startSeqReq);
  c_short_latched: cover property ($rose(shortLatch_q));
  c_otp_release: cover property ($fell(overTempSync) && !shortLatch_q);
  c_hist_clear: cover property (restartHist_q ##1 !restartHist_q);

endmodule : sprc_top

/* sprc_pkg.sv */
// shared constants and types of the supply restart and protection controller
package sprc_pkg;

  // register port geometry
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 8;

  // register offsets
  localparam logic [7:0] ADDR_RESTART_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATE_FLAGS = 8'h05;
  localparam logic [7:0] ADDR_SCRATCH = 8'h06;

  // restart control field positions
  localparam int RESTART_HIST_BIT = 7;
  localparam int HOLD_SEL_HI = 5;
  localparam int HOLD_SEL_LO = 4;
  localparam int RESTART_REQ_BIT = 0;
  localparam logic [7:0] RESTART_CLEAR_VALUE = 8'h00;

  // state flag field positions
  localparam int STATE_SHORT_BIT = 3;
  localparam int STATE_OVERTEMP_BIT = 2;
  localparam int STATE_OSC_BIT = 1;
  localparam int STATE_ENABLE_BIT = 0;

  // reset values
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [1:0] HOLD_SEL_RESET = 2'h0;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam logic [4:0] HOLD_MS_00 = 5'h01;
  localparam logic [4:0] HOLD_MS_01 = 5'h04;
  localparam logic [4:0] HOLD_MS_10 = 5'h08;
  localparam logic [4:0] HOLD_MS_11 = 5'h10;
  localparam logic [6:0] SHORT_QUAL_MS = 7'h64;

  // regulator outputs under control, always-on regulator excluded
  localparam int NUM_OUT_DEFAULT = 6;

  typedef enum logic [3:0] {
    RS_IDLE = 4'b0001,
    RS_STOP = 4'b0010,
    RS_HOLD = 4'b0100,
    RS_START = 4'b1000
  } sprc_restart_state_t;

endpackage : sprc_pkg

/* sprc_sync.sv */
// two-flop synchroniser for the comparator and pin flags
`timescale 1ns/10ps
module sprc_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // flags
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule : sprc_sync

/* sprc_seq_model.sv */
// regulator sequencer model that answers stop requests after a chosen delay
`timescale 1ns/10ps
module sprc_seq_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // delay chosen by the bench, at least 1
  input wire logic [7:0] doneDelay,
  // sequencer handshake
  input wire logic stopSeqReq,
  output logic stopSeqDone
);
  logic [7:0] cntQ;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cntQ <= 8'h00;
      stopSeqDone <= 1'b0;
    end else begin
      stopSeqDone <= (cntQ == 8'h01);
      if (stopSeqReq) begin
        cntQ <= doneDelay;
      end else if (cntQ != 8'h00) begin
        cntQ <= cntQ - 8'h01;
      end
    end
  end
endmodule : sprc_seq_model

/* supply_restart_and_protection_ctrl_tb_top.sv */
// self-checking bench of the supply restart and protection controller
`timescale 1ns/10ps
module supply_restart_and_protection_ctrl_tb_top;
  import sprc_pkg::*;
  localparam int NOUT = 6;
  localparam int CPMS = 4;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic softReset = 1'b0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic shortDetectRaw = 1'b0;
  logic overTempRaw = 1'b0;
  logic crystalOscRaw = 1'b0;
  logic supplyEnablePinRaw = 1'b0;
  logic [NOUT-1:0] curLimitRaw = 6'h00;
  logic [NOUT-1:0] belowShortLevelRaw = 6'h00;
  logic stopSeqReq;
  logic stopSeqDone;
  logic startSeqReq;
  logic [NOUT-1:0] outputStop;
  logic [7:0] doneDelay = 8'h01;
  logic [31:0] rngQ = 32'h0000df5e;
  int numErrors = 0;
  int nTests = 0;

  always #25 sys_clk = ~sys_clk;

  sprc_top #(.NUM_OUT(NOUT), .CYCLES_PER_MS(CPMS)) DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .softReset(softReset),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData),
    .shortDetectRaw(shortDetectRaw), .overTempRaw(overTempRaw),
    .crystalOscRaw(crystalOscRaw), .supplyEnablePinRaw(supplyEnablePinRaw),
    .curLimitRaw(curLimitRaw), .belowShortLevelRaw(belowShortLevelRaw),
    .stopSeqReq(stopSeqReq), .stopSeqDone(stopSeqDone),
    .startSeqReq(startSeqReq), .outputStop(outputStop)
  );

  sprc_seq_model seqModel (
    .sys_clk(sys_clk), .arst_n(arst_n), .doneDelay(doneDelay),
    .stopSeqReq(stopSeqReq), .stopSeqDone(stopSeqDone)
  );

  function automatic logic [31:0] nextRnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : nextRnd

  function automatic int holdMs(input logic [1:0] sel);
    case (sel)
      2'h0: return 1;
      2'h1: return 4;
      2'h2: return 8;
      default: return 16;
    endcase
  endfunction : holdMs

  task automatic printVerdict();
    $display("errors %0d, checks %0d", numErrors, nTests);
    if (numErrors == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : printVerdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= dt;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] dt);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    cyc(1);
    dt = regRdData;
  endtask : rd

  // power-on reset held two cycles, as the undervoltage lockout would
  task automatic doReset();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    cyc(1);
  endtask : doReset

  initial begin : mainSeq
    logic [7:0] v;
    logic [7:0] d;
    int n;
    int lo;
    int hi;
    doReset();
    for (int a = 4; a < 7; a++) begin
      rd(8'(a), d);
      chk(d, 8'h00, "reset value");
    end
    repeat (4) begin
      rngQ = nextRnd(rngQ);
      v = rngQ[7:0];
      wr(ADDR_SCRATCH, v);
      rd(ADDR_SCRATCH, d);
      chk(d, v, "scratch");
    end
    // write then read in back-to-back cycles
    rngQ = nextRnd(rngQ);
    v = rngQ[15:8];
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= ADDR_SCRATCH;
    regWrData <= v;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    cyc(1);
    chk(regRdData, v, "scratch back to back");
    wr(ADDR_STATE_FLAGS, 8'hff);
    rd(ADDR_STATE_FLAGS, d);
    chk(d, 8'h00, "state write");
    rd(8'h07, d);
    chk(d, 8'h00, "unmapped");
    @(posedge sys_clk);
    softReset <= 1'b1;
    @(posedge sys_clk);
    softReset <= 1'b0;
    rd(ADDR_SCRATCH, d);
    chk(d, 8'h00, "soft reset");
    // random flag patterns; short pulses stay far below the qualification time
    repeat (8) begin
      rngQ = nextRnd(rngQ);
      v = {4'h0, rngQ[3:0]};
      @(posedge sys_clk);
      shortDetectRaw <= v[3];
      overTempRaw <= v[2];
      crystalOscRaw <= v[1];
      supplyEnablePinRaw <= v[0];
      cyc(4);
      rd(ADDR_STATE_FLAGS, d);
      chk(d, v, "state flags");
      chk({2'h0, outputStop}, v[2] ? 8'h3f : 8'h00, "overtemp stop");
    end
    // all flag pins back low, so later state reads see only what they set
    @(posedge sys_clk);
    shortDetectRaw <= 1'b0;
    overTempRaw <= 1'b0;
    crystalOscRaw <= 1'b0;
    supplyEnablePinRaw <= 1'b0;
    // every hold code, prompt and slow sequencer, history set by each write and still set after the restart
    for (int s = 0; s < 4; s++) begin
      doneDelay <= s[0] ? 8'h0c : 8'h01;
      wr(ADDR_RESTART_CTRL, {2'b00, 2'(s), 4'h1});
      cyc(0);
      chk({7'h00, stopSeqReq}, 8'h01, "stop req");
      rd(ADDR_RESTART_CTRL, d);
      chk(d, {2'b10, 2'(s), 4'h1}, "pending");
      n = 3;
      while (startSeqReq !== 1'b1 && n < 200) begin
        cyc(1);
        n++;
      end
      if (n >= 200) begin
        numErrors++;
        $display("MISMATCH t=%0t restart timed out", $time);
        printVerdict();
      end
      lo = (s[0] ? 12 : 1) + holdMs(2'(s)) * CPMS;
      hi = lo + CPMS + 6;
      chk({7'h00, n >= lo && n <= hi}, 8'h01, "hold length");
      rd(ADDR_RESTART_CTRL, d);
      chk(d, {2'b10, 2'(s), 4'h0}, "after restart");
    end
    wr(ADDR_RESTART_CTRL, 8'h00);
    rd(ADDR_RESTART_CTRL, d);
    chk(d, 8'h00, "history clear");
    wr(ADDR_RESTART_CTRL, 8'hce);
    rd(ADDR_RESTART_CTRL, d);
    chk(d, 8'h00, "history set ignored");
    // current limit on one output latches that output only
    rngQ = nextRnd(rngQ);
    n = int'(rngQ[15:0]) % NOUT;
    @(posedge sys_clk);
    curLimitRaw[n] <= 1'b1;
    belowShortLevelRaw[n] <= 1'b1;
    cyc(8);
    curLimitRaw <= 6'h00;
    belowShortLevelRaw <= 6'h00;
    cyc(6);
    chk({2'h0, outputStop}, 8'h01 << n, "current limit");
    wr(ADDR_SCRATCH, 8'ha5);
    doReset();
    chk({2'h0, outputStop}, 8'h00, "por stop");
    rd(ADDR_SCRATCH, d);
    chk(d, 8'h00, "por scratch");
    // short held past the qualification time
    @(posedge sys_clk);
    shortDetectRaw <= 1'b1;
    cyc(390);
    chk({2'h0, outputStop}, 8'h00, "early short");
    rd(ADDR_STATE_FLAGS, d);
    chk(d, 8'h08, "short flag");
    n = 0;
    while (outputStop !== 6'h3f && n < 60) begin
      cyc(1);
      n++;
    end
    chk({2'h0, outputStop}, 8'h3f, "short stop");
    @(posedge sys_clk);
    shortDetectRaw <= 1'b0;
    cyc(10);
    chk({2'h0, outputStop}, 8'h3f, "short latch");
    doReset();
    chk({2'h0, outputStop}, 8'h00, "short release");
    printVerdict();
  end
endmodule : supply_restart_and_protection_ctrl_tb_top
